/* cpsc_power_ctrl.sv */
// Power state controller: host boot and shutdown moves plus the overtemp countdown.
`timescale 1ns/100ps
`include "cpsc_defines.svh"

module cpsc_power_ctrl #(
	parameter logic [`CPSC_CNT_W-1:0] OT_CYCLES = `CPSC_OT_CYCLES
) (
	input  wire logic                    SYS_CLK,
	input  wire logic                    RST,
	input  wire logic                    SUPPLY_GOOD,
	input  wire logic                    RESET_N,
	input  wire logic                    SHUTDOWN_REQUEST_N,
	input  wire logic                    SW_SHUTDOWN_CMD,
	input  wire logic                    SW_WAKE_CMD,
	input  wire logic [`CPSC_TEMP_W-1:0] TEMP_C,
	output logic                         FUNCTIONS_EN,
	output logic                         SHUTDOWN_IMMINENT,
	output logic [`CPSC_STATE_W-1:0]     STATE_CODE,
	output cpsc_pkg::cpsc_status_t       STATUS
);
	cpsc_pkg::cpsc_state_t         state_q;
	cpsc_pkg::cpsc_state_t         state_d;
	logic [`CPSC_CNT_W-1:0]        cnt_q;
	logic [`CPSC_CNT_W-1:0]        cnt_d;
	logic                          shdn_pin_q;
	logic                          hot;
	logic                          cool;
	logic                          pin_fall;
	logic                          pin_rise;
	logic                          expired;
	logic                          go_on;
	logic                          go_down;
	logic                          enter_ot;
	logic                          in_on;
	logic                          in_ot;
	logic                          host_reset;
	logic                          supply_lost;
	logic                          boot_ok;
	logic                          ot_cool_exit;
	logic                          ot_timeout;
	logic                          cnt_run;
	logic [`CPSC_CNT_W-1:0]        cnt_load;
	logic [`CPSC_CNT_W-1:0]        cnt_dec;
	logic                          funcs_d;
	logic                          imminent_d;
	logic [`CPSC_STATE_W-1:0]      code_d;
	cpsc_pkg::cpsc_status_t        status_d;

	function automatic logic [`CPSC_STATE_W-1:0] code_of(input cpsc_pkg::cpsc_state_t s);
		case (s)
			cpsc_pkg::CPSC_OFF:      code_of = `CPSC_ST_OFF;
			cpsc_pkg::CPSC_UNINIT:   code_of = `CPSC_ST_UNINIT;
			cpsc_pkg::CPSC_ON:       code_of = `CPSC_ST_ON;
			cpsc_pkg::CPSC_SHUTDOWN: code_of = `CPSC_ST_SHUTDOWN;
			cpsc_pkg::CPSC_OVERTEMP: code_of = `CPSC_ST_OVERTEMP;
			default:                 code_of = `CPSC_ST_OFF;
		endcase
	endfunction

	// Functions stay usable during the overtemp warning window, so the host can still read
	// the warning and wind down its work before the drop to shutdown.
	function automatic logic funcs_of(input cpsc_pkg::cpsc_state_t s);
		case (s)
			cpsc_pkg::CPSC_ON:       funcs_of = 1'b1;
			cpsc_pkg::CPSC_OVERTEMP: funcs_of = 1'b1;
			default:                 funcs_of = 1'b0;
		endcase
	endfunction

	function automatic logic imminent_of(input cpsc_pkg::cpsc_state_t s);
		case (s)
			cpsc_pkg::CPSC_OVERTEMP: imminent_of = 1'b1;
			default:                 imminent_of = 1'b0;
		endcase
	endfunction

	// Exactly at the limit the sensor is neither hot nor cool, so overtemp holds and keeps
	// counting there instead of chattering between two states.
	assign hot      = TEMP_C > `CPSC_TEMP_LIMIT_C;
	assign cool     = TEMP_C < `CPSC_TEMP_LIMIT_C;
	// Pin edges are used so a held level does not fight a later software command.
	assign pin_fall = shdn_pin_q & ~SHUTDOWN_REQUEST_N;
	assign pin_rise = ~shdn_pin_q & SHUTDOWN_REQUEST_N;
	assign go_on    = pin_rise | SW_WAKE_CMD;
	assign go_down  = pin_fall | SW_SHUTDOWN_CMD;
	assign expired      = (cnt_q == '0);
	assign in_on        = (state_q == cpsc_pkg::CPSC_ON);
	assign in_ot        = (state_q == cpsc_pkg::CPSC_OVERTEMP);
	assign host_reset   = ~RESET_N;
	assign supply_lost  = ~SUPPLY_GOOD;
	assign boot_ok      = RESET_N & SHUTDOWN_REQUEST_N;
	assign ot_cool_exit = in_ot & cool;
	assign ot_timeout   = in_ot & ~cool & expired;
	// Loading only on a real move into overtemp keeps a reset or a shutdown that wins in
	// the same cycle from arming a countdown that no state will use.
	assign enter_ot     = in_on & (state_d == cpsc_pkg::CPSC_OVERTEMP);
	assign cnt_run      = in_ot & ~expired;
	// The counter is wide enough for ten seconds at this clock; a much faster clock would
	// need a wider counter as well as a new span.
	assign cnt_load     = OT_CYCLES - 1'b1;
	assign cnt_dec      = cnt_q - 1'b1;

	// The priority is fixed: loss of supply first, then a host reset, then a shutdown
	// request, then the temperature paths. A shutdown that the host asks for therefore
	// always beats the automatic overtemp moves in the same cycle.
	always_comb begin
		state_d = state_q;
		// Loss of supply always wins, from every state.
		if (supply_lost) begin
			state_d = cpsc_pkg::CPSC_OFF;
		end else begin
			case (state_q)
				cpsc_pkg::CPSC_OFF: begin
					state_d = cpsc_pkg::CPSC_UNINIT;
				end
				cpsc_pkg::CPSC_UNINIT: begin
					// Boot follows the pin levels alone: reset high with the pin high, no host edge needed.
					if (boot_ok) begin
						state_d = cpsc_pkg::CPSC_ON;
					end
				end
				cpsc_pkg::CPSC_ON: begin
					if (host_reset) begin
						state_d = cpsc_pkg::CPSC_UNINIT;
					end else if (go_down) begin
						state_d = cpsc_pkg::CPSC_SHUTDOWN;
					end else if (hot) begin
						state_d = cpsc_pkg::CPSC_OVERTEMP;
					end
				end
				cpsc_pkg::CPSC_SHUTDOWN: begin
					if (host_reset) begin
						state_d = cpsc_pkg::CPSC_UNINIT;
					end else if (go_on) begin
						state_d = cpsc_pkg::CPSC_ON;
					end
				end
				cpsc_pkg::CPSC_OVERTEMP: begin
					if (host_reset) begin
						state_d = cpsc_pkg::CPSC_UNINIT;
					end else if (go_down) begin
						state_d = cpsc_pkg::CPSC_SHUTDOWN;
					end else if (ot_cool_exit) begin
						state_d = cpsc_pkg::CPSC_ON;
					end else if (ot_timeout) begin
						state_d = cpsc_pkg::CPSC_SHUTDOWN;
					end
				end
				default: begin
					state_d = cpsc_pkg::CPSC_OFF;
				end
			endcase
		end
	end

	// The count is loaded on entry, so a fresh entry always gets the full span.
	assign cnt_d = enter_ot ? cnt_load :
		cnt_run ? cnt_dec : cnt_q;

	// Next values of the outputs follow state_d, so they move at the same edge as the
	// state itself, with no extra cycle of lag.
	assign funcs_d    = funcs_of(state_d);
	assign imminent_d = imminent_of(state_d);
	assign code_d     = code_of(state_d);
	assign status_d   = '{functions_en:      funcs_d,
		shutdown_imminent: imminent_d,
		state_code:        code_d};

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= cpsc_pkg::CPSC_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// A cleared count reads as expired, which is harmless because the count is only looked
	// at in overtemp and every entry reloads it first.
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// The pin sampler resets to the idle level of the pin so that no false edge follows reset.
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			shdn_pin_q <= `CPSC_PIN_IDLE;
		end else begin
			shdn_pin_q <= SHUTDOWN_REQUEST_N;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			FUNCTIONS_EN      <= 1'b0;
			SHUTDOWN_IMMINENT <= 1'b0;
			STATE_CODE        <= `CPSC_ST_OFF;
			STATUS            <= '0;
		end else begin
			FUNCTIONS_EN      <= funcs_d;
			SHUTDOWN_IMMINENT <= imminent_d;
			STATE_CODE        <= code_d;
			STATUS            <= status_d;
		end
	end
endmodule

/* cpsc_defines.svh */
// Timing constants and encodings for the camera power state controller.
`ifndef CPSC_DEFINES_SVH
`define CPSC_DEFINES_SVH
`define CPSC_CLK_HZ        125000000
`define CPSC_OT_SECONDS    10
`define CPSC_OT_CYCLES     (`CPSC_CLK_HZ * `CPSC_OT_SECONDS)
`define CPSC_CNT_W         32
`define CPSC_TEMP_W        12
`define CPSC_TEMP_LIMIT_C  12'h050
`define CPSC_STATE_W       3
`define CPSC_PIN_IDLE      1'b1
`define CPSC_ST_OFF        3'h0
`define CPSC_ST_UNINIT     3'h1
`define CPSC_ST_ON         3'h2
`define CPSC_ST_SHUTDOWN   3'h3
`define CPSC_ST_OVERTEMP   3'h4
`endif

/* cpsc_pkg.sv */
// Types shared by the camera power state controller.
package cpsc_pkg;
	typedef enum {
		CPSC_OFF,
		CPSC_UNINIT,
		CPSC_ON,
		CPSC_SHUTDOWN,
		CPSC_OVERTEMP
	} cpsc_state_t;

	typedef struct packed {
		logic functions_en;
		logic shutdown_imminent;
		logic [2:0] state_code;
	} cpsc_status_t;
endpackage

/* cpsc_host_model.sv */
// Host model driving the camera's active-low reset and shutdown pins.
`timescale 1ns/100ps
module cpsc_host_model (
	input  wire logic clk,
	input  wire logic do_reset,
	input  wire logic do_sleep,
	output logic      reset_n,
	output logic      shutdown_request_n
);
	// Pins are levels that change just after an edge, as a real host would.
	initial begin
		reset_n = 1'b1;
		shutdown_request_n = 1'b1;
		forever begin
			@(posedge clk);
			reset_n <= !do_reset;
			shutdown_request_n <= !do_sleep;
		end
	end
endmodule

/* cpsc_power_ctrl_checker.sv */
// Port checker for the camera power state controller.
`timescale 1ns/100ps
`include "cpsc_defines.svh"
module cpsc_power_ctrl_checker #(
	parameter logic [`CPSC_CNT_W-1:0] OT_CYCLES = 32'h14
) (
	input wire logic                    SYS_CLK,
	input wire logic                    RST,
	input wire logic                    SUPPLY_GOOD,
	input wire logic                    RESET_N,
	input wire logic                    SHUTDOWN_REQUEST_N,
	input wire logic                    SW_SHUTDOWN_CMD,
	input wire logic                    SW_WAKE_CMD,
	input wire logic [`CPSC_TEMP_W-1:0] TEMP_C,
	input wire logic                    FUNCTIONS_EN,
	input wire logic                    SHUTDOWN_IMMINENT,
	input wire logic [`CPSC_STATE_W-1:0] STATE_CODE
);
	localparam int OTW = OT_CYCLES + 1;
	default clocking dc @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	wire quiet = RESET_N && SUPPLY_GOOD && SHUTDOWN_REQUEST_N && !SW_SHUTDOWN_CMD;
	chk_state_legal: assert property (STATE_CODE <= 3'h4) else $error("bad state");
	chk_on_funcs: assert property (STATE_CODE == 3'h2 |-> FUNCTIONS_EN) else $error("on off");
	chk_shdn_idle: assert property (STATE_CODE == 3'h3 |-> !FUNCTIONS_EN) else $error("sd fn");
	chk_hot_entry: assert property (
		STATE_CODE == 3'h2 && quiet && TEMP_C > 12'h050 |=> STATE_CODE == 3'h4)
		else $error("no overtemp");
	chk_imminent_bit: assert property (SHUTDOWN_IMMINENT == (STATE_CODE == 3'h4))
		else $error("imminent bit");
	chk_cool_exit: assert property (
		STATE_CODE == 3'h4 && quiet && TEMP_C < 12'h050 |=> STATE_CODE == 3'h2)
		else $error("no recovery");
	chk_ot_timeout: assert property (
		$rose(SHUTDOWN_IMMINENT) |-> ##[1:OTW] !SHUTDOWN_IMMINENT) else $error("countdown long");
	chk_no_selfwake: assert property (
		STATE_CODE == 3'h3 && !SW_WAKE_CMD && !$rose(SHUTDOWN_REQUEST_N) |=> STATE_CODE != 3'h2)
		else $error("self wake");
	chk_sw_wake: assert property (
		STATE_CODE == 3'h3 && SW_WAKE_CMD && RESET_N && SUPPLY_GOOD |=> STATE_CODE == 3'h2)
		else $error("wake lost");
	chk_supply_off: assert property (!SUPPLY_GOOD |=> STATE_CODE == 3'h0)
		else $error("supply lost");
	chk_host_reset: assert property (SUPPLY_GOOD && !RESET_N |=> STATE_CODE == 3'h1)
		else $error("reset ignored");
endmodule
bind cpsc_power_ctrl cpsc_power_ctrl_checker #(.OT_CYCLES(OT_CYCLES)) cpsc_power_ctrl_checker_i (
	.SYS_CLK(SYS_CLK), .RST(RST), .SUPPLY_GOOD(SUPPLY_GOOD), .RESET_N(RESET_N),
	.SHUTDOWN_REQUEST_N(SHUTDOWN_REQUEST_N), .SW_SHUTDOWN_CMD(SW_SHUTDOWN_CMD),
	.SW_WAKE_CMD(SW_WAKE_CMD), .TEMP_C(TEMP_C), .FUNCTIONS_EN(FUNCTIONS_EN),
	.SHUTDOWN_IMMINENT(SHUTDOWN_IMMINENT), .STATE_CODE(STATE_CODE));

/* tb_camera_power_state_control.sv */
// Self-checking testbench for the camera power state controller.
`timescale 1ns/100ps
module tb_camera_power_state_control;
	localparam logic [31:0] OT = 32'h14;
	logic clk = 1'b0, rst = 1'b1, sg = 1'b0, drs = 1'b0, dsl = 1'b0, sws = 1'b0, swk = 1'b0;
	logic [11:0] temp = 12'h019;
	logic rn, sn, fe, si;
	logic [2:0] sc;
	cpsc_pkg::cpsc_status_t st;
	int n_mismatch = 0, tests_run = 0, n;
	cpsc_host_model cpsc_host_model_i (.clk(clk), .do_reset(drs), .do_sleep(dsl), .reset_n(rn),
		.shutdown_request_n(sn));
	cpsc_power_ctrl #(.OT_CYCLES(OT)) cpsc_power_ctrl_i (.SYS_CLK(clk), .RST(rst),
		.SUPPLY_GOOD(sg), .RESET_N(rn), .SHUTDOWN_REQUEST_N(sn), .SW_SHUTDOWN_CMD(sws),
		.SW_WAKE_CMD(swk), .TEMP_C(temp), .FUNCTIONS_EN(fe), .SHUTDOWN_IMMINENT(si),
		.STATE_CODE(sc), .STATUS(st));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Bounded wait for a state; a miss ends the run since later steps depend on it.
	task automatic wt(input logic [2:0] e, output int c);
		c = 0;
		while (sc !== e && c < 100) begin
			@(posedge clk);
			#1;
			c++;
		end
		chk({5'h00, sc}, {5'h00, e});
		if (sc !== e) complete_run();
	endtask
	task automatic t_boot();
		@(posedge clk) sg <= 1'b1;
		wt(3'h2, n);
		chk({7'h00, fe}, 8'h01);
		chk({3'h0, st}, 8'h12);
	endtask
	task automatic t_pin();
		@(posedge clk) dsl <= 1'b1;
		wt(3'h3, n);
		chk({7'h00, fe}, 8'h00);
		chk({3'h0, st}, 8'h03);
		@(posedge clk) dsl <= 1'b0;
		wt(3'h2, n);
	endtask
	task automatic t_sw();
		@(posedge clk) sws <= 1'b1;
		@(posedge clk) sws <= 1'b0;
		wt(3'h3, n);
		@(posedge clk) swk <= 1'b1;
		@(posedge clk) swk <= 1'b0;
		wt(3'h2, n);
	endtask
	task automatic t_ot(input logic hot);
		@(posedge clk) temp <= 12'h051;
		wt(3'h4, n);
		chk({7'h00, si}, 8'h01);
		chk({7'h00, fe}, 8'h01);
		chk({3'h0, st}, 8'h1C);
		if (hot) begin
			wt(3'h3, n);
			chk(n[7:0], OT[7:0]);
			@(posedge clk) temp <= 12'h019;
			@(posedge clk) swk <= 1'b1;
			@(posedge clk) swk <= 1'b0;
		end else begin
			@(posedge clk) temp <= 12'h050;
			repeat (3) @(posedge clk);
			#1 chk({5'h00, sc}, 8'h04);
			@(posedge clk) temp <= 12'h04F;
		end
		wt(3'h2, n);
		chk({7'h00, si}, 8'h00);
	endtask
	task automatic t_rst();
		@(posedge clk) drs <= 1'b1;
		wt(3'h1, n);
		@(posedge clk) drs <= 1'b0;
		wt(3'h2, n);
	endtask
	// Mid-run loss of supply or a mid-run reset pulse, then the climb back to on.
	task automatic t_off(input logic by_rst);
		@(posedge clk) {rst, sg} <= by_rst ? 2'b11 : 2'b00;
		@(posedge clk);
		#1 chk({5'h00, sc}, 8'h00);
		chk({3'h0, st}, 8'h00);
		@(posedge clk) {rst, sg} <= 2'b01;
		wt(3'h2, n);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_boot();
		t_pin();
		t_sw();
		t_ot(1'b0);
		t_ot(1'b1);
		t_rst();
		t_off(1'b0);
		t_off(1'b1);
		complete_run();
	end
endmodule
